// *** src/asc_pkg.sv ***
// Package: register map, field layout and constants of the sample and clock control block
package asc_pkg;
    // Register byte addresses (AXI4-Lite word aligned)
    localparam logic [3:0]  ASC_OFF_ENABLE_CTRL   = 4'h0;
    localparam logic [3:0]  ASC_OFF_SAMPLE_CLK    = 4'h4;
    localparam int          ASC_ADDR_W            = 4;

    // Enable control register fields
    localparam int          ASC_ENC_BIT           = 1;
    localparam int          ASC_START_BIT         = 0;

    // Sample, clock and sequence control register fields
    localparam int          ASC_REG_W             = 16;
    localparam int          ASC_TRIG_LSB          = 10;
    localparam int          ASC_PULSE_BIT         = 9;
    localparam int          ASC_INVERT_BIT        = 8;
    localparam int          ASC_DIV_LSB           = 5;
    localparam int          ASC_CSRC_LSB          = 3;
    localparam int          ASC_SEQ_LSB           = 1;
    localparam int          ASC_BUSY_BIT          = 0;
    localparam logic [15:0] ASC_SAMPLE_CLK_RESET  = 16'h0000;

    // Trigger source codes
    typedef enum logic [1:0] {
        ASC_TRIG_SOFT   = 2'b00,
        ASC_TRIG_TIMER0 = 2'b01,
        ASC_TRIG_TIMER1 = 2'b10,
        ASC_TRIG_TIMER2 = 2'b11
    } asc_trig_t;

    // Conversion clock source codes
    typedef enum logic [1:0] {
        ASC_CLK_MODOSC  = 2'b00,
        ASC_CLK_AUX     = 2'b01,
        ASC_CLK_MAIN    = 2'b10,
        ASC_CLK_SUBMAIN = 2'b11
    } asc_csrc_t;

    // Sequence modes
    typedef enum logic [1:0] {
        ASC_SEQ_SINGLE     = 2'b00,
        ASC_SEQ_SEQUENCE   = 2'b01,
        ASC_SEQ_REP_SINGLE = 2'b10,
        ASC_SEQ_REP_SEQ    = 2'b11
    } asc_seq_t;

    // AXI responses
    localparam logic [1:0]  ASC_RESP_OKAY         = 2'b00;
    localparam logic [1:0]  ASC_RESP_SLVERR       = 2'b10;

    // Sampling timer default length in conversion clock ticks
    localparam int          ASC_SAMPLE_TICKS      = 4;
endpackage : asc_pkg

// *** src/asc_sample_clock_ctrl.sv ***
// Sample trigger, conversion clock and sequence control register block with AXI4-Lite slave
//
// Behaviour
// - Config fields are changed by software only with conversion enable clear; writes to them are ignored while it is set.
// - After enable is cleared, a new config value acts at once, even mid conversion.
// - Trigger source field bits 11-10 picks software start (00b) or timer trigger 0, 1, 2.
// - Bit 9 makes the sampling control follow the sample input (0) or the sampling timer (1).
// - Bit 8 set inverts the sample input before use.
// - Bits 4-3 pick the conversion clock source and bits 7-5 divide it by value plus one.
// - Bits 2-1 select single, sequence, repeat single or repeat sequence mode.
// - Read-only bit 0 reads 1 while a sequence, sample or conversion is active, else 0, reset 0.
// - Bits 15-12 always read zero.
// - Conversion enable bit off disables the converter, on enables it.
// - Software start bit written 1 requests a sample and clears itself; may be set with enable.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
module asc_sample_clock_ctrl
    import asc_pkg::*;
#(
    parameter int SAMPLE_TICKS = ASC_SAMPLE_TICKS
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // AXI4-Lite write address
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [ASC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // AXI4-Lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [ASC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    // AXI4-Lite read data
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // Asynchronous clock sources and timer triggers (sampled)
    input  wire logic [3:0]            clk_src_i,
    input  wire logic [2:0]            timer_trig_i,
    // Converter core side
    input  wire logic                  core_busy_i,
    output logic                       conv_tick_o,
    output logic                       sampling_control_signal_o,
    output logic                       conversion_enable_o,
    output logic [1:0]                 sequence_mode_sel_o
);
    localparam int NUM_EXT = 7;

    // Byte-lane merge used for both registers
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ---------------- Registers ----------------
    logic                  enc_q;
    logic                  sw_req_q;
    logic [11:1]           cfg_q;
    logic [11:1]           cfg_d;

    // ---------------- AXI write channel ----------------
    logic                  aw_full_q;
    logic [ASC_ADDR_W-1:0] aw_addr_q;
    logic                  w_full_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;

    wire                   aw_take    = s_axi_awvalid & s_axi_awready;
    wire                   w_take     = s_axi_wvalid & s_axi_wready;
    wire                   aw_have    = aw_full_q | aw_take;
    wire                   w_have     = w_full_q | w_take;
    wire                   wr_fire    = aw_have & w_have & ~bvalid_q;
    wire [ASC_ADDR_W-1:0]  wr_addr    = aw_full_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0]            wr_data    = w_full_q ? w_data_q : s_axi_wdata;
    wire [3:0]             wr_strb    = w_full_q ? w_strb_q : s_axi_wstrb;
    wire                   wr_enable  = wr_fire & (wr_addr == ASC_OFF_ENABLE_CTRL);
    wire                   wr_smp_clk = wr_fire & (wr_addr == ASC_OFF_SAMPLE_CLK);
    wire                   wr_mapped  = wr_enable | wr_smp_clk;

    // Holding registers free the channel; address and data may arrive in either order
    assign s_axi_awready = ~aw_full_q & ~bvalid_q;
    assign s_axi_wready  = ~w_full_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ASC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ---------------- Enable and software start ----------------
    wire [31:0] en_merged = merge_lanes({30'h0, enc_q, 1'b0}, wr_data, wr_strb);
    wire        sw_write  = wr_enable & en_merged[ASC_START_BIT];
    wire        sw_go     = sw_write & en_merged[ASC_ENC_BIT];
    logic       conv_tick;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            enc_q <= 1'b0;
        end else if (wr_enable) begin
            enc_q <= en_merged[ASC_ENC_BIT];
        end
    end

    // Start request lasts until the next conversion clock tick or until enable clears, then clears itself
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sw_req_q <= 1'b0;
        end else if (sw_go) begin
            sw_req_q <= 1'b1;
        end else if (conv_tick | ~enc_q) begin
            sw_req_q <= 1'b0;
        end
    end

    // ---------------- Sample, clock and sequence register ----------------
    wire [31:0] cfg_merged = merge_lanes({20'h0, cfg_q, 1'b0}, wr_data, wr_strb);

    // Enable as held before this write decides; clearing it first opens the fields
    always_comb begin
        cfg_d = cfg_q;
        if (wr_smp_clk && !enc_q) begin
            cfg_d = cfg_merged[11:1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= ASC_SAMPLE_CLK_RESET[11:1];
        end else begin
            cfg_q <= cfg_d;
        end
    end

    asc_trig_t  trig_sel;
    asc_csrc_t  csrc_sel;
    wire        pulse_sel  = cfg_q[ASC_PULSE_BIT];
    wire        invert_sel = cfg_q[ASC_INVERT_BIT];
    wire [2:0]  div_sel    = cfg_q[ASC_DIV_LSB +: 3];
    assign trig_sel            = asc_trig_t'(cfg_q[ASC_TRIG_LSB +: 2]);
    assign csrc_sel            = asc_csrc_t'(cfg_q[ASC_CSRC_LSB +: 2]);
    assign sequence_mode_sel_o = cfg_q[ASC_SEQ_LSB +: 2];
    assign conversion_enable_o = enc_q;

    // ---------------- Input synchronisers ----------------
    wire  [NUM_EXT-1:0] ext_in = {timer_trig_i, clk_src_i};
    logic [NUM_EXT-1:0] ext_lvl;
    logic [NUM_EXT-1:0] ext_rise;

    for (genvar g = 0; g < NUM_EXT; g++) begin : g_sync
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic lvl_q;
        logic lvl_prev_q;
        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                s1_q       <= 1'b0;
                s2_q       <= 1'b0;
                s3_q       <= 1'b0;
                lvl_q      <= 1'b0;
                lvl_prev_q <= 1'b0;
            end else begin
                s1_q       <= ext_in[g];
                s2_q       <= s1_q;
                s3_q       <= s2_q;
                lvl_prev_q <= lvl_q;
                if (s2_q == s3_q) begin
                    lvl_q <= s3_q;
                end
            end
        end
        assign ext_lvl[g]  = lvl_q;
        assign ext_rise[g] = lvl_q & ~lvl_prev_q;
    end

    // ---------------- Conversion clock divider ----------------
    logic [2:0] div_cnt_q;
    logic       src_prev_q;
    // A source switch can bring the new source's edge one cycle after the old one's;
    // that edge is dropped so the conversion clock never runs at the full clock rate
    wire        src_tick = ext_rise[csrc_sel] & ~src_prev_q;
    wire        div_wrap = div_cnt_q >= div_sel;

    // Compare with >= so a smaller divide value never strands the count;
    // every output tick still follows a whole source edge, so no runt period
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= '0;
        end else if (src_tick) begin
            div_cnt_q <= div_wrap ? 3'h0 : div_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_tick;
        end
    end

    assign conv_tick   = src_tick & div_wrap;
    assign conv_tick_o = conv_tick;

    // ---------------- Sample input and sampling control ----------------
    wire [3:0] trig_vec  = {ext_lvl[6:4], sw_req_q};
    wire       shi_raw   = trig_vec[trig_sel];
    wire       shi       = (shi_raw ^ invert_sel) & enc_q;
    logic      shi_prev_q;
    logic      tmr_run_q;
    logic [$clog2(SAMPLE_TICKS+1)-1:0] tmr_cnt_q;
    localparam logic [$clog2(SAMPLE_TICKS+1)-1:0] TMR_LAST =
        ($clog2(SAMPLE_TICKS+1))'(SAMPLE_TICKS - 1);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            shi_prev_q <= 1'b0;
        end else begin
            shi_prev_q <= shi;
        end
    end

    wire shi_rise = shi & ~shi_prev_q;

    // Sampling timer counts conversion ticks from a rising sample input
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tmr_run_q <= 1'b0;
            tmr_cnt_q <= '0;
        end else if (!enc_q || !pulse_sel) begin
            tmr_run_q <= 1'b0;
            tmr_cnt_q <= '0;
        end else if (!tmr_run_q && shi_rise) begin
            tmr_run_q <= 1'b1;
            tmr_cnt_q <= '0;
        end else if (tmr_run_q && conv_tick) begin
            if (tmr_cnt_q == TMR_LAST) begin
                tmr_run_q <= 1'b0;
            end
            tmr_cnt_q <= tmr_cnt_q + 1'b1;
        end
    end

    wire sampling_control_signal = pulse_sel ? tmr_run_q : shi;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sampling_control_signal_o <= 1'b0;
        end else begin
            sampling_control_signal_o <= sampling_control_signal;
        end
    end

    // Busy covers a pending start, the sample phase as driven out and the core's work;
    // the registered output keeps busy up in the cycle after the timer ends
    wire busy = sw_req_q | tmr_run_q | sampling_control_signal | sampling_control_signal_o | core_busy_i;

    // ---------------- AXI read channel ----------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire         rd_take    = s_axi_arvalid & s_axi_arready;
    wire         rd_enable  = s_axi_araddr == ASC_OFF_ENABLE_CTRL;
    wire         rd_smp_clk = s_axi_araddr == ASC_OFF_SAMPLE_CLK;
    wire [31:0]  enable_val = {30'h0, enc_q, sw_req_q};
    wire [31:0]  smp_val    = {16'h0, 4'h0, cfg_q, busy};
    wire [31:0]  rd_val     = rd_enable ? enable_val : (rd_smp_clk ? smp_val : 32'h0);

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= ASC_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= (rd_enable | rd_smp_clk) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : asc_sample_clock_ctrl

// *** tb/asc_sample_clock_ctrl_monitor.sv ***
// Concurrent checks on the ports of the sample, clock and sequence control block
module asc_sample_clock_ctrl_monitor
    import asc_pkg::*;
#(
    parameter int SAMPLE_TICKS = ASC_SAMPLE_TICKS
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // Converter side
    input wire logic        core_busy_i,
    input wire logic        conv_tick_o,
    input wire logic        sampling_control_signal_o,
    input wire logic        conversion_enable_o,
    input wire logic [1:0]  sequence_mode_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire  wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    wire  rd_go = s_axi_arvalid && s_axi_arready;
    wire  wr_sc = wr_go && s_axi_awaddr == ASC_OFF_SAMPLE_CLK;
    logic pulse_q;
    // Mirror of the pulse mode bit, so direct mode can be recognised at the ports
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pulse_q <= 1'h0;
        end else if (wr_sc && !conversion_enable_o && s_axi_wstrb[1]) begin
            pulse_q <= s_axi_wdata[ASC_PULSE_BIT];
        end
    end
    AST_TICK_PULSE: assert property (conv_tick_o |=> !conv_tick_o)
        else $error("conversion tick held longer than one cycle");
    AST_LOCKED_FIELDS: assert property (wr_sc && conversion_enable_o |=>
        $stable(sequence_mode_sel_o) && s_axi_bvalid && s_axi_bresp == ASC_RESP_OKAY)
        else $error("configuration changed while enabled");
    AST_SEQ_WRITE: assert property (wr_sc && !conversion_enable_o |=>
        sequence_mode_sel_o == $past(s_axi_wdata[2:1]))
        else $error("sequence mode not taken from write");
    AST_ENABLE_WRITE: assert property (wr_go && s_axi_awaddr == ASC_OFF_ENABLE_CTRL |=>
        conversion_enable_o == $past(s_axi_wdata[ASC_ENC_BIT]))
        else $error("enable output does not follow write");
    AST_RESERVED_ZERO: assert property (rd_go |=> s_axi_rvalid && s_axi_rdata[31:12] == 20'h0)
        else $error("reserved read bits not zero");
    AST_BUSY_READ: assert property (rd_go && s_axi_araddr == ASC_OFF_SAMPLE_CLK &&
        (core_busy_i || sampling_control_signal_o) |=> s_axi_rdata[ASC_BUSY_BIT] == 1'h1)
        else $error("busy bit low during activity");
    AST_START_IDLE: assert property (rd_go && s_axi_araddr == ASC_OFF_ENABLE_CTRL &&
        !conversion_enable_o && !$past(conversion_enable_o) |=> s_axi_rdata[ASC_START_BIT] == 1'h0)
        else $error("start request pending while disabled");
    AST_DIRECT_OFF: assert property (!pulse_q && !conversion_enable_o |=>
        !sampling_control_signal_o)
        else $error("direct sampling active while disabled");
endmodule // asc_sample_clock_ctrl_monitor

bind asc_sample_clock_ctrl asc_sample_clock_ctrl_monitor #(.SAMPLE_TICKS(SAMPLE_TICKS)) u_mon (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .core_busy_i(core_busy_i), .conv_tick_o(conv_tick_o),
    .sampling_control_signal_o(sampling_control_signal_o),
    .conversion_enable_o(conversion_enable_o), .sequence_mode_sel_o(sequence_mode_sel_o));

// *** tb/asc_core_model.sv ***
// Behavioural model of the converter core and of the conversion clock sources
module asc_core_model (
    // Clock and reset
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    // Control block side
    input  wire logic  conv_tick_i,
    input  wire logic  sampling_i,
    input  wire logic  enable_i,
    input  wire logic  slow_i,
    // Sources and status
    output logic [3:0] clk_src_o,
    output logic       busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt_q  = 0;
    logic       samp_q = 1'h0;
    logic [3:0] left_q = 4'h0;
    // Source k toggles every k+2 cycles, so each source has a distinct period
    for (genvar k = 0; k < 4; k++) begin : g_src
        assign clk_src_o[k] = ((cnt_q / (k + 2)) % 2) == 1;
    end
    always_ff @(posedge ref_clk_i) begin
        cnt_q  <= cnt_q + 1;
        samp_q <= sampling_i;
        if (!rst_n_i) begin
            left_q <= 4'h0;
        end else if (samp_q && !sampling_i && enable_i) begin
            left_q <= slow_i ? 4'h9 : 4'h3;
        end else if (conv_tick_i && left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end
    assign busy_o = left_q != 4'h0;
endmodule // asc_core_model

// *** tb/tb.sv ***
// Self-checking bench for the sample, clock and sequence control block
module tb
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         ST   = 3;
    localparam logic [3:0] EN_A = ASC_OFF_ENABLE_CTRL;
    localparam logic [3:0] SC_A = ASC_OFF_SAMPLE_CLK;
    logic        ref_clk_i = 1'h0;
    logic        rst_n_i   = 1'h0;
    logic        aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0, slow = 1'h0;
    logic [3:0]  aw_a = 4'h0, ar_a = 4'h0, clk_src;
    logic [31:0] w_d  = 32'h0, q, r_d;
    logic [2:0]  trig = 3'h0;
    logic [1:0]  r, b_resp, r_resp, seq;
    logic        aw_r, w_r, b_v, ar_r, r_v, busy, tick, samp, en;
    int          mismatches = 0, checked = 0, hi_ticks = 0;

    always #4 ref_clk_i = ~ref_clk_i;
    logic        tick_d = 1'h0;
    // Sampling control lags the timer by a cycle, so each tick is matched a cycle late
    always @(negedge ref_clk_i) begin
        if (samp && tick_d) hi_ticks++;
        tick_d = tick;
    end

    asc_sample_clock_ctrl #(.SAMPLE_TICKS(ST)) uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
        .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_bresp(b_resp), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .clk_src_i(clk_src),
        .timer_trig_i(trig), .core_busy_i(busy), .conv_tick_o(tick),
        .sampling_control_signal_o(samp), .conversion_enable_o(en), .sequence_mode_sel_o(seq));
    asc_core_model u_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .conv_tick_i(tick),
        .sampling_i(samp), .enable_i(en), .slow_i(slow), .clk_src_o(clk_src), .busy_o(busy));

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s: got %0h expected %0h", $time, m, got, exp);
        end
    endtask

    // One bus transfer; returns at a falling edge with q and r holding the answer
    task automatic xfer(input bit wr, input logic [3:0] a, input logic [31:0] d);
        int   n;
        logic aw_t, w_t, ar_t, dn;
        n = 0;
        @(posedge ref_clk_i);
        if (wr) begin
            aw_a <= a;
            w_d  <= d;
            aw_v <= 1'h1;
            w_v  <= 1'h1;
            b_r  <= 1'h1;
        end else begin
            ar_a <= a;
            ar_v <= 1'h1;
            r_r  <= 1'h1;
        end
        do begin
            @(negedge ref_clk_i);
            aw_t = aw_v & aw_r;
            w_t  = w_v & w_r;
            ar_t = ar_v & ar_r;
            dn   = wr ? b_v : r_v;
            r    = wr ? b_resp : r_resp;
            q    = r_d;
            n++;
            @(posedge ref_clk_i);
            if (aw_t) aw_v <= 1'h0;
            if (w_t) w_v <= 1'h0;
            if (ar_t) ar_v <= 1'h0;
        end while (!dn && n < 200);
        b_r <= 1'h0;
        r_r <= 1'h0;
        if (!dn) chk(0, 1, "bus answer missing");
        @(negedge ref_clk_i);
    endtask

    task automatic t_reset;
        xfer(0, SC_A, 0);
        chk(q, ASC_SAMPLE_CLK_RESET, "control reset value");
        xfer(0, EN_A, 0);
        chk(q, 32'h0, "enable reset value");
        xfer(0, 4'h8, 0);
        chk(r, ASC_RESP_SLVERR, "unmapped read");
        $display("reset test done");
    endtask

    task automatic t_fields;
        xfer(1, SC_A, 32'hFFFF_FFFF);
        xfer(0, SC_A, 0);
        chk(q, 32'h0000_0FFE, "field readback");
        for (int m = 0; m < 4; m++) begin
            xfer(1, SC_A, 32'(m * 2));
            chk(seq, m, "sequence mode");
        end
        $display("field test done");
    endtask

    task automatic t_lock;
        xfer(1, SC_A, 32'h2);
        xfer(1, EN_A, 32'h2);
        chk(en, 1, "enable set");
        xfer(1, SC_A, 32'h0FFC);
        chk(r, ASC_RESP_OKAY, "locked write answer");
        xfer(0, SC_A, 0);
        chk(q[11:1], 11'h001, "locked fields");
        xfer(1, EN_A, 0);
        $display("lock test done");
    endtask

    task automatic t_pulse;
        int n;
        n = 0;
        xfer(1, SC_A, 32'h0206);
        @(posedge ref_clk_i);
        slow <= 1'h1;
        hi_ticks = 0;
        xfer(1, EN_A, 32'h3);
        while ((samp || hi_ticks == 0) && n < 300) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(hi_ticks, ST, "sampling timer length");
        xfer(0, SC_A, 0);
        chk(q[0], 1, "busy while converting");
        xfer(0, EN_A, 0);
        chk(q[0], 0, "start bit self clears");
        xfer(1, EN_A, 0);
        xfer(1, SC_A, 32'h0204);
        chk(seq, 2, "change while converting");
        xfer(0, SC_A, 0);
        chk(q[11:0], 12'h205, "busy kept with new fields");
        @(posedge ref_clk_i);
        slow <= 1'h0;
        while (busy && n < 900) begin
            @(negedge ref_clk_i);
            n++;
        end
        xfer(0, SC_A, 0);
        chk(q[0], 0, "idle after conversion");
        $display("pulse test done");
    endtask

    task automatic t_direct;
        logic [2:0] off;
        for (int c = 1; c < 4; c++) begin
            for (int v = 0; v < 2; v++) begin
                off = v ? 3'(1 << (c - 1)) : ~3'(1 << (c - 1));
                xfer(1, EN_A, 0);
                xfer(1, SC_A, 32'(c * 1024 + v * 256));
                @(posedge ref_clk_i);
                trig <= off;
                xfer(1, EN_A, 32'h2);
                repeat (8) @(negedge ref_clk_i);
                chk(samp, 0, "unselected trigger");
                @(posedge ref_clk_i);
                trig <= ~off;
                repeat (8) @(negedge ref_clk_i);
                chk(samp, 1, "selected trigger");
            end
        end
        $display("direct test done");
    endtask

    task automatic gap(output int g);
        g = 0;
        do begin
            @(negedge ref_clk_i);
            g++;
        end while (!tick && g < 200);
    endtask

    task automatic t_div;
        int g;
        xfer(1, EN_A, 0);
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 8; d += 7) begin
                xfer(1, SC_A, 32'(d * 32 + s * 8));
                repeat (3) gap(g);
                chk(g, (d + 1) * 2 * (s + 2), "tick spacing");
            end
        end
        $display("divider test done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        t_reset;
        t_fields;
        t_lock;
        t_pulse;
        t_direct;
        t_div;
        give_verdict;
    end

    // Whole run needs about a thousand cycles; this margin only catches a hang
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        give_verdict;
    end
endmodule // tb
